// file: kpi_keys.sv
// Key switch model driving the port pins
`timescale 1ns/1ps
module kpi_keys (
    input wire logic core_clk,
    input wire logic [5:0] key_down,
    input wire logic [5:0] pin_pullup_on,
    input wire logic [5:0] pin_output_allow,
    output logic [5:0] port_pins_in
);
    logic [5:0] drift_ff = 6'h00;
    // Unpulled open lines wander, so a missing pullup shows up
    always_ff @(posedge core_clk)
    begin
        drift_ff <= ~drift_ff;
    end
    // Output pins hold port data written as 1 before their enable is set
    assign port_pins_in = ~key_down & (pin_pullup_on | pin_output_allow | drift_ff);
endmodule

// file: kpi_pkg.sv
// Package of register map, field positions and reset values for the key interrupt unit
package kpi_pkg;
    localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h1A;
    localparam logic [7:0] PIN_ENABLE_OFFSET = 8'h1B;
    localparam int PIN_COUNT = 6;
    // Status/control fields
    localparam int TRIGGER_LEVEL_BIT = 0;
    localparam int IRQ_MASK_BIT = 1;
    localparam int IRQ_ACK_BIT = 2;
    localparam int PENDING_BIT = 3;
    // Enable register fields
    localparam int WAKEUP_ENABLE_BIT = 6;
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
    localparam logic [15:0] IRQ_VECTOR_HIGH_ADDR = 16'hFFE0;
    localparam logic [15:0] IRQ_VECTOR_LOW_ADDR = 16'hFFE1;
endpackage

// file: kpi_sync.sv
// Two-stage synchroniser for the key input pins
`timescale 1ns/1ps
module kpi_sync (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [5:0] async_in,
    output logic [5:0] sync_out
);
    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] stable;
    } kpi_sync_t;

    kpi_sync_t state_ff;
    kpi_sync_t nxt_state;

    // First stage feeds only the second; idle level is high (pullups)
    always_comb
    begin
        nxt_state.meta = async_in;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= {6'h3F, 6'h3F};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;
endmodule

// file: kpi_unit.sv
// Key pin interrupt unit: pin latch, wakeup latch, mask, acknowledge and registers
`timescale 1ns/1ps
module kpi_unit (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] port_pins_in,
    input wire logic [5:0] port_direction,
    input wire logic [5:0] port_pullup_enable,
    output logic [5:0] pin_output_allow,
    output logic [5:0] pin_pullup_on,
    output logic [5:0] pin_read_valid,
    input wire logic wakeup_timer_request,
    input wire logic vector_fetch,
    input wire logic break_active,
    input wire logic break_clear_enable,
    output logic wakeup_irq_enable,
    output logic irq_request,
    output logic wake_request
);
    typedef struct packed {
        logic trigger_level_select;
        logic irq_mask;
        logic [5:0] pin_irq_enable;
        logic wakeup_irq_enable;
        logic pin_latch;
        logic wakeup_latch;
        logic ack_seen;
        logic [5:0] prev_pins;
        logic [7:0] rdata;
    } kpi_unit_t;

    kpi_unit_t state_ff;
    kpi_unit_t nxt_state;
    logic [5:0] pins_sync;

    // Pin levels cross into the bus clock here
    kpi_sync u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(port_pins_in),
        .sync_out(pins_sync)
    );

    // Masked view: a disabled pin looks high so it never triggers
    function automatic logic any_low(input logic [5:0] lvl, input logic [5:0] en);
        any_low = |(~lvl & en);
    endfunction

    logic sc_sel;
    logic en_sel;
    logic ack_wr;
    logic ack_pulse;
    logic ack_allowed;
    logic now_low;
    logic was_low;
    logic fall_trigger;
    logic pending;
    logic [7:0] status_view;

    always_comb
    begin
        sc_sel = (reg_addr == kpi_pkg::STATUS_CONTROL_OFFSET);
        en_sel = (reg_addr == kpi_pkg::PIN_ENABLE_OFFSET);
        // Break blocks the register acknowledge unless the break-clear enable is set; vector fetch still clears the pin latch
        ack_allowed = !break_active || break_clear_enable;
        ack_wr = reg_wr && sc_sel && reg_wdata[kpi_pkg::IRQ_ACK_BIT] && ack_allowed;
        ack_pulse = ack_wr || vector_fetch;
        now_low = any_low(pins_sync, state_ff.pin_irq_enable);
        was_low = any_low(state_ff.prev_pins, state_ff.pin_irq_enable);
        // Only the all-high to some-low step counts, which also blocks
        // edges while another enabled pin is held low
        fall_trigger = now_low && !was_low;
        pending = state_ff.pin_latch || state_ff.wakeup_latch;
        status_view = 8'h00;
        status_view[kpi_pkg::PENDING_BIT] = pending;
        status_view[kpi_pkg::IRQ_MASK_BIT] = state_ff.irq_mask;
        status_view[kpi_pkg::TRIGGER_LEVEL_BIT] = state_ff.trigger_level_select;
    end

    // Next-state logic for registers and latches
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.prev_pins = pins_sync;
        if (reg_wr && sc_sel)
        begin
            nxt_state.irq_mask = reg_wdata[kpi_pkg::IRQ_MASK_BIT];
            nxt_state.trigger_level_select = reg_wdata[kpi_pkg::TRIGGER_LEVEL_BIT];
        end
        if (reg_wr && en_sel)
        begin
            nxt_state.pin_irq_enable = reg_wdata[5:0];
            // Held only for the wakeup timer, no pin effect
            nxt_state.wakeup_irq_enable = reg_wdata[kpi_pkg::WAKEUP_ENABLE_BIT];
        end
        // Pin latch: acknowledge clears, new edge in same cycle wins
        // Level mode remembers an ack taken while a pin is still low,
        // so the latch drops once every enabled pin is back high
        if (ack_pulse)
        begin
            if (!state_ff.trigger_level_select || !now_low)
            begin
                nxt_state.pin_latch = 1'b0;
                nxt_state.ack_seen = 1'b0;
            end
            else
            begin
                nxt_state.ack_seen = 1'b1;
            end
        end
        if (state_ff.trigger_level_select && state_ff.ack_seen && !now_low)
        begin
            nxt_state.pin_latch = 1'b0;
            nxt_state.ack_seen = 1'b0;
        end
        // Level mode: any enabled low pin keeps the request up
        if (state_ff.trigger_level_select && now_low)
        begin
            nxt_state.pin_latch = 1'b1;
        end
        if (fall_trigger)
        begin
            nxt_state.pin_latch = 1'b1;
            nxt_state.ack_seen = 1'b0;
        end
        // Wakeup latch ignores vector fetch
        if (ack_wr)
        begin
            nxt_state.wakeup_latch = 1'b0;
        end
        if (wakeup_timer_request)
        begin
            nxt_state.wakeup_latch = 1'b1;
        end
        nxt_state.rdata = 8'h00;
        if (reg_rd && sc_sel)
        begin
            nxt_state.rdata = status_view;
        end
        else if (reg_rd && en_sel)
        begin
            nxt_state.rdata = {1'b0, state_ff.wakeup_irq_enable, state_ff.pin_irq_enable};
        end
    end

    // Asynchronous reset clears control, enables and latches
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff.trigger_level_select <= 1'b0;
            state_ff.irq_mask <= 1'b0;
            state_ff.pin_irq_enable <= 6'h00;
            state_ff.wakeup_irq_enable <= 1'b0;
            state_ff.pin_latch <= 1'b0;
            state_ff.wakeup_latch <= 1'b0;
            state_ff.ack_seen <= 1'b0;
            state_ff.prev_pins <= 6'h3F;
            state_ff.rdata <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Port-facing controls; an enabled pin is an input with pullup
    assign pin_pullup_on = port_pullup_enable | state_ff.pin_irq_enable;
    assign pin_output_allow = port_direction & ~state_ff.pin_irq_enable;
    assign pin_read_valid = ~port_direction;
    assign wakeup_irq_enable = state_ff.wakeup_irq_enable;
    assign reg_rdata = state_ff.rdata;
    // No clock gating here, so requests wake the core from wait/stop
    assign irq_request = (state_ff.pin_latch || state_ff.wakeup_latch)
        && !state_ff.irq_mask;
    assign wake_request = irq_request;
endmodule

// file: kpi_unit_bench.sv
// Self-checking bench for the key interrupt unit
`timescale 1ns/1ps
module kpi_unit_bench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [5:0] pins, pull, oa, dir = 6'h00, pue = 6'h00, kd = 6'h00;
    logic wtr = 1'b0, vf = 1'b0, brk = 1'b0, bce = 1'b0, rd_d = 1'b0, irq, wie;
    logic [7:0] exp_q[$];
    int num_errors = 0, num_checks = 0, k;
    initial forever #2 core_clk = ~core_clk;
    kpi_unit i_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .port_pins_in(pins), .port_direction(dir), .port_pullup_enable(pue),
        .pin_output_allow(oa), .pin_pullup_on(pull), .pin_read_valid(),
        .wakeup_timer_request(wtr), .vector_fetch(vf), .break_active(brk),
        .break_clear_enable(bce), .wakeup_irq_enable(wie), .irq_request(irq), .wake_request());
    kpi_keys i_keys (.core_clk, .key_down(kd), .pin_pullup_on(pull),
        .pin_output_allow(oa), .port_pins_in(pins));
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Gap cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic fetch;
        vf <= 1'b1;
        @(posedge core_clk);
        vf <= 1'b0;
    endtask
    // Six cycles covers the synchroniser and latch delay
    task automatic ck(input logic e);
        repeat (6) @(posedge core_clk);
        cmp({7'h00, irq}, {7'h00, e});
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Read data stand one cycle after the strobe
    always @(posedge core_clk)
    begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0)
            cmp(reg_rdata, exp_q.pop_front());
    end
    initial
    begin
        k = $urandom(7);
        dir <= 6'($urandom);
        pue <= 6'($urandom);
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(8'h1A, 8'h00);
        rd(8'h1B, 8'h00);
        rd(8'h1C, 8'h00);
        wr(8'h1A, 8'h02);
        wr(8'h1B, 8'h7F);
        rd(8'h1B, 8'h7F);
        cmp({7'h00, wie}, 8'h01);
        repeat (4) @(posedge core_clk);
        wr(8'h1A, 8'h06);
        wr(8'h1A, 8'h00);
        k = $urandom % 6;
        kd <= 6'h01 << k;
        ck(1'b1);
        rd(8'h1A, 8'h08);
        wr(8'h1A, 8'h04);
        ck(1'b0);
        kd <= kd | (6'h01 << ((k + 1) % 6));
        ck(1'b0);
        kd <= 6'h00;
        ck(1'b0);
        kd <= 6'h01 << k;
        ck(1'b1);
        fetch();
        ck(1'b0);
        kd <= 6'h00;
        wr(8'h1A, 8'h01);
        kd <= 6'h01 << k;
        ck(1'b1);
        wr(8'h1A, 8'h05);
        ck(1'b1);
        kd <= 6'h00;
        ck(1'b0);
        kd <= 6'h01 << k;
        ck(1'b1);
        kd <= 6'h00;
        ck(1'b1);
        fetch();
        ck(1'b0);
        wr(8'h1A, 8'h03);
        kd <= 6'h01 << k;
        ck(1'b0);
        kd <= 6'h00;
        rd(8'h1A, 8'h0B);
        wr(8'h1A, 8'h07);
        rd(8'h1A, 8'h03);
        wtr <= 1'b1;
        @(posedge core_clk);
        wtr <= 1'b0;
        rd(8'h1A, 8'h0B);
        wr(8'h1A, 8'h01);
        ck(1'b1);
        fetch();
        ck(1'b1);
        brk <= 1'b1;
        wr(8'h1A, 8'h05);
        ck(1'b1);
        bce <= 1'b1;
        wr(8'h1A, 8'h05);
        brk <= 1'b0;
        ck(1'b0);
        wr(8'h1B, 8'h00);
        kd <= 6'h01 << k;
        ck(1'b0);
        wr(8'h1B, 8'h3F);
        ck(1'b1);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(8'h1A, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        test_done();
    end
endmodule

// file: kpi_unit_chk.sv
// Port checker for the key interrupt unit
`timescale 1ns/1ps
module kpi_unit_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] port_direction,
    input wire logic [5:0] port_pullup_enable,
    input wire logic [5:0] pin_output_allow,
    input wire logic [5:0] pin_pullup_on,
    input wire logic [5:0] pin_read_valid,
    input wire logic irq_request,
    input wire logic wake_request
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    rd_zero_a: assert property (reg_rd && reg_addr == 8'h1A |=>
        reg_rdata[7:4] == 4'h0 && !reg_rdata[2]) else $error("status read bits");
    unmapped_rd_a: assert property (reg_rd && reg_addr != 8'h1A && reg_addr != 8'h1B
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    pend_flag_a: assert property (reg_rd && reg_addr == 8'h1A && irq_request
        |=> reg_rdata[3] && !reg_rdata[1]) else $error("pending flag");
    pullup_keep_a: assert property (
        (pin_pullup_on & port_pullup_enable) == port_pullup_enable) else $error("pullup");
    force_in_a: assert property ((port_direction & ~pin_output_allow & ~port_pullup_enable) ==
        (pin_pullup_on & port_direction & ~port_pullup_enable)) else $error("input force");
    read_valid_a: assert property (pin_read_valid == ~port_direction)
        else $error("read valid");
    wake_same_a: assert property (wake_request == irq_request)
        else $error("wake request");
    mask_block_a: assert property (reg_wr && reg_addr == 8'h1A && reg_wdata[1]
        |=> !irq_request) else $error("mask");
endmodule
bind kpi_unit kpi_unit_chk i_chk (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_direction, .port_pullup_enable, .pin_output_allow, .pin_pullup_on,
    .pin_read_valid, .irq_request, .wake_request);
